// ===== pwmd_pkg.sv
package pwmd_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int             CHANNELS      = 4;
   localparam int             DUTY_W        = 12;
   localparam int             SUB_W         = 8;
   localparam int             FINE_W        = 4;
   localparam int             ADDR_W        = 4;
   localparam int             DATA_W        = 8;
   // ----------------------------------------
   // register map: offset = 2*channel + pair half
   // ----------------------------------------
   localparam logic [3:0]     OFS_DUTY_LO0  = 4'h0;
   localparam logic [3:0]     OFS_DUTY_HI0  = 4'h1;
   localparam logic [3:0]     OFS_PORT_DIR  = 4'h8;
   localparam logic [3:0]     OFS_PORT_DATA = 4'h9;
   localparam logic [3:0]     OFS_STATUS    = 4'hA;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int             EN_BIT        = 0;
   localparam int             FINE_LSB      = 4;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0]     RST_DUTY      = 8'h00;
   localparam logic [3:0]     RST_DIR       = 4'hF;
   localparam logic [3:0]     RST_DATA      = 4'h0;
   // ----------------------------------------
   // timing (clock counts)
   // ----------------------------------------
   localparam int             SUB_CLOCKS    = 256;
   localparam int             SUB_CYCLES    = 16;
   localparam int             PERIOD_CLOCKS = SUB_CLOCKS * SUB_CYCLES;
endpackage : pwmd_pkg

// ===== pwmd_tick_if.sv
`timescale 1ns/1ns
interface pwmd_tick_if;
   logic [7:0] phase;
   logic [3:0] sub_idx;
   logic       period_start;
   modport src (output phase, output sub_idx, output period_start);
   modport dst (input phase, input sub_idx, input period_start);
endinterface : pwmd_tick_if

// ===== pwmd_timebase.sv
`timescale 1ns/1ns
module pwmd_timebase
(
   // clock and reset
   input  wire logic     CLK,
   input  wire logic     RESETN,
   // shared timebase
   pwmd_tick_if.src      tick
);
   typedef struct packed
   {
      logic [11:0] cnt;
   } pwmd_tb_s;

   pwmd_tb_s st_r;
   pwmd_tb_s st_nxt;

   // free-running 4096-clock counter, no software involvement
   always_comb
   begin
      st_nxt     = st_r;
      st_nxt.cnt = st_r.cnt + 12'h001;
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tick.phase        = st_r.cnt[7:0];
   assign tick.sub_idx      = st_r.cnt[11:8];
   assign tick.period_start = (st_r.cnt == 12'h000);
endmodule : pwmd_timebase

// ===== pwmd_channel.sv
`timescale 1ns/1ns
module pwmd_channel
(
   // clock and reset
   input  wire logic              CLK,
   input  wire logic              RESETN,
   // configuration
   input  wire logic [11:0]       duty,
   // shared timebase
   pwmd_tick_if.dst               tick,
   // waveform
   output logic                   wave
);
   typedef struct packed
   {
      logic [11:0] act;
      logic        wave;
   } pwmd_ch_s;

   pwmd_ch_s   st_r;
   pwmd_ch_s   st_nxt;
   logic [11:0] use_duty;
   logic [8:0]  high_len;

   always_comb
   begin
      st_nxt   = st_r;
      // latch the new value only at the period boundary
      use_duty = tick.period_start ? duty : st_r.act;
      st_nxt.act = use_duty;
      // coarse plus one extra clock in sub-cycles below the fine value
      high_len = {1'b0, use_duty[11:4]}
               + ((tick.sub_idx < use_duty[3:0]) ? 9'h001 : 9'h000);
      st_nxt.wave = ({1'b0, tick.phase} < high_len);
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign wave = st_r.wave;
endmodule : pwmd_channel

// ===== pwmd_top.sv
`timescale 1ns/1ns
module pwmd_top
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESETN,
   // register port
   input  wire logic [3:0]  ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   // shared port pins
   input  wire logic [3:0]  PIN_IN,
   output logic      [3:0]  PIN_OUT,
   output logic      [3:0]  PIN_OE,
   // pull-high enable towards the pad, active in input mode
   output logic      [3:0]  PIN_PULL,
   // plain port input value, synchronised
   output logic      [3:0]  PORT_IN
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed
   {
      logic [3:0][7:0] duty_lo;
      logic [3:0][7:0] duty_hi;
      logic [3:0]      dir;
      logic [3:0]      pdata;
      logic [3:0]      pull;
      logic [3:0]      sync1;
      logic [3:0]      sync2;
      logic [7:0]      rdata;
      logic [3:0]      pout;
   } pwmd_top_s;

   pwmd_top_s  st_r;
   pwmd_top_s  st_nxt;
   logic [3:0] wave;
   logic [3:0] en;

   pwmd_tick_if tick ();

   // ----------------------------------------
   // shared timebase and channels
   // ----------------------------------------
   pwmd_timebase u_tb
   (
      .CLK    (CLK),
      .RESETN (RESETN),
      .tick   (tick.src)
   );

   for (genvar c = 0; c < pwmd_pkg::CHANNELS; c++)
   begin : g_ch
      pwmd_channel u_ch
      (
         .CLK    (CLK),
         .RESETN (RESETN),
         .duty   ({st_r.duty_hi[c], st_r.duty_lo[c][7:pwmd_pkg::FINE_LSB]}),
         .tick   (tick.dst),
         .wave   (wave[c])
      );
      assign en[c] = st_r.duty_lo[c][pwmd_pkg::EN_BIT];
   end

   // ----------------------------------------
   // registers and pin mux
   // ----------------------------------------
   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.sync1 = PIN_IN;
      st_nxt.sync2 = st_r.sync1;
      if (WR)
      begin
         if (ADDR < pwmd_pkg::OFS_PORT_DIR)
         begin
            if (ADDR[0] == pwmd_pkg::OFS_DUTY_HI0[0])
               st_nxt.duty_hi[ADDR[2:1]] = WDATA;
            else
               st_nxt.duty_lo[ADDR[2:1]] = WDATA & 8'hF1;
         end
         else if (ADDR == pwmd_pkg::OFS_PORT_DIR)
            st_nxt.dir = WDATA[3:0];
         else if (ADDR == pwmd_pkg::OFS_PORT_DATA)
            st_nxt.pdata = WDATA[3:0];
         else if (ADDR == pwmd_pkg::OFS_STATUS)
            st_nxt.pull = WDATA[3:0];
      end
      st_nxt.rdata = 8'h00;
      if (RD)
      begin
         if (ADDR < pwmd_pkg::OFS_PORT_DIR)
            st_nxt.rdata = ADDR[0] ? st_r.duty_hi[ADDR[2:1]] : st_r.duty_lo[ADDR[2:1]];
         else if (ADDR == pwmd_pkg::OFS_PORT_DIR)
            st_nxt.rdata = {4'h0, st_r.dir};
         else if (ADDR == pwmd_pkg::OFS_PORT_DATA)
            st_nxt.rdata = {st_r.sync2, st_r.pdata};
         else if (ADDR == pwmd_pkg::OFS_STATUS)
            st_nxt.rdata = {wave, st_r.pull};
      end
      // enabled: data bit gates the waveform, else plain port latch
      for (int c = 0; c < 4; c++)
         st_nxt.pout[c] = en[c] ? (wave[c] & st_r.pdata[c]) : st_r.pdata[c];
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st_r       <= '0;
         st_r.dir   <= pwmd_pkg::RST_DIR;
         st_r.pdata <= pwmd_pkg::RST_DATA;
      end
      else
         st_r <= st_nxt;
   end

   assign RDATA    = st_r.rdata;
   assign PIN_OUT  = st_r.pout;
   // direction one is input regardless of enable; software must clear it
   assign PIN_OE   = ~st_r.dir;
   assign PIN_PULL = st_r.pull & st_r.dir;
   assign PORT_IN  = st_r.sync2;
endmodule : pwmd_top

// ===== pwmd_top_asserts.sv
`timescale 1ns/1ns
module pwmd_top_asserts
(
   // clock and reset
   input wire logic       CLK,
   input wire logic       RESETN,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   // pins
   input wire logic [3:0] PIN_IN,
   input wire logic [3:0] PIN_OUT,
   input wire logic [3:0] PIN_OE,
   input wire logic [3:0] PIN_PULL,
   input wire logic [3:0] PORT_IN
);
   // ----------
   // checks
   // ----------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rdata");
   a_hi_back: assert property (WR && ADDR == 4'h1 ##1 RD && ADDR == 4'h1
      |=> RDATA == $past(WDATA, 2)) else $error("hi readback");
   a_lo_mask: assert property (RD && ADDR < 4'h8 && !ADDR[0] |=> RDATA[3:1] == 3'h0)
      else $error("lo mask");
   a_unmapped_zero: assert property (RD && ADDR > 4'hA |=> RDATA == 8'h00)
      else $error("unmapped");
   a_oe_dir: assert property (WR && ADDR == 4'h8 |=> PIN_OE == ~$past(WDATA[3:0]))
      else $error("oe");
   a_pull_input: assert property ((PIN_PULL & PIN_OE) == 4'h0) else $error("pull");
   a_pull_set: assert property (WR && ADDR == 4'hA
      |=> PIN_PULL == ($past(WDATA[3:0]) & ~PIN_OE)) else $error("pull set");
   a_sync_in: assert property ($past(RESETN, 2) |-> PORT_IN == $past(PIN_IN, 2))
      else $error("port in");
   a_data_off: assert property (WR && ADDR == 4'h9 && WDATA[3:0] == 4'h0 ##1 !WR [*2]
      |=> PIN_OUT == 4'h0) else $error("off low");
endmodule : pwmd_top_asserts
bind pwmd_top pwmd_top_asserts u_chk (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
   .PIN_PULL(PIN_PULL), .PORT_IN(PORT_IN));

// ===== pwmd_load.sv
`timescale 1ns/1ns
module pwmd_load
(
   // clock
   input wire logic       clk,
   // pad side
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] pin_pull,
   output logic     [3:0] pin_in
);
   logic [3:0] last_r = 4'h0;
   // a floating pad shows the inverse of its last level, never a stale match
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pull | ~last_r));
   always_ff @(posedge clk) last_r <= pin_in;
endmodule : pwmd_load

// ===== test_pwmd_top.sv
`timescale 1ns/1ns
module test_pwmd_top;
   // ----------
   // bench
   // ----------
   localparam int CH = 1;
   logic        clk, rst_n, wr, rd, rd_seen = 1'b0;
   logic [3:0]  addr, pin_in, pin_out, pin_oe, pin_pull, port_in;
   logic [7:0]  wdata, rdata;
   logic [31:0] seed = 32'h49DE;
   logic [11:0] rq[$], pq[$];
   int          n_mismatch = 0, samples_checked = 0, run = 0, gap = 0;
   pwmd_top uut (.CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
      .PIN_PULL(pin_pull), .PORT_IN(port_in));
   pwmd_load u_load (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull(pin_pull),
      .pin_in(pin_in));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   // a read notes its expected data; the monitor compares it one cycle later
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      if (!w) rq.push_back({4'h0, d});
   endtask : bus
   // strobes drop one edge after the last request, never in the same time step
   task automatic bus_idle;
      @(posedge clk);
      {wr, rd} <= 2'b00;
   endtask : bus_idle
   task automatic duty(input logic [11:0] d);
      bus(1'b1, 4'(2 * CH + 1), d[11:4]);
      bus(1'b1, 4'(2 * CH), {d[3:0], 4'h1});
      for (int i = 0; i < 16; i++) pq.push_back(12'(d[11:4]) + 12'(i < d[3:0]));
   endtask : duty
   task automatic test_done;
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   always @(posedge clk)
   begin
      if (rd_seen) chk("rdata", {4'h0, rdata}, rq.pop_front());
      rd_seen <= rd;
      // rising edges of a running train are one sub-cycle apart
      if (pin_out[CH] && run == 0)
      begin
         if (gap != 0) chk("sub-cycle", gap[11:0], 12'(pwmd_pkg::SUB_CLOCKS));
         gap = 0;
      end
      if (gap != 0 || pin_out[CH])
         gap++;
      if (pin_out[CH])
         run++;
      else if (run != 0)
      begin
         chk("high time", run[11:0], (pq.size() != 0) ? pq.pop_front() : 12'h000);
         run = 0;
      end
   end
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #400000;
      n_mismatch++;
      test_done();
   end
   initial
   begin
      rst_n = 1'b0;
      {wr, rd, addr, wdata} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 4'h8, 8'h0F);
      bus(1'b0, 4'hC, 8'h00);
      bus(1'b1, 4'hA, 8'h0F);
      // every channel latched its zero duty at the first period start, so every waveform bit reads zero
      bus(1'b0, 4'hA, 8'h0F);
      for (int c = 0; c < 4; c++)
      begin
         seed = xs(seed);
         bus(1'b1, 4'(2 * c + 1), seed[7:0]);
         bus(1'b0, 4'(2 * c + 1), seed[7:0]);
         bus(1'b1, 4'(2 * c), 8'hFE);
         bus(1'b0, 4'(2 * c), 8'hF0);
      end
      // all pins are inputs with pull-high by now, so the synced level is high
      bus(1'b0, 4'h9, 8'hF0);
      bus(1'b1, 4'(2 * CH + 1), 8'h00);
      bus(1'b1, 4'(2 * CH), 8'h00);
      bus_idle();
      $display("register test done");
      repeat (4100) @(posedge clk);
      seed = xs(seed);
      duty({8'(seed[7:0] % 200 + 1), seed[11:8]});
      bus(1'b1, 4'h9, 8'(1 << CH));
      bus(1'b1, 4'h8, 8'(~(1 << CH)));
      bus_idle();
      @(posedge clk);
      chk("pin enable", {8'h00, pin_oe}, 12'(1 << CH));
      chk("pull-high", {8'h00, pin_pull}, 12'(4'hF & ~(1 << CH)));
      for (int k = 0; k < 5000 && !pin_out[CH]; k++) @(posedge clk);
      repeat (1000) @(posedge clk);
      // second value lands mid-period: the first must still finish whole
      duty({8'(seed[23:16] % 200 + 1), seed[27:24]});
      bus_idle();
      for (int k = 0; k < 9000 && pq.size() != 0; k++) @(posedge clk);
      bus(1'b1, 4'h9, 8'h00);
      bus_idle();
      repeat (600) @(posedge clk);
      chk("held low", {11'h000, pin_out[CH]}, 12'h000);
      chk("pulses left", 12'(pq.size()), 12'h000);
      $display("waveform test done");
      test_done();
   end
endmodule : test_pwmd_top
